// file: design/fac_limits.sv
// Summary of operation
// RULE_01: ramp code maps to steps 1..48
// RULE_02: remote-two fans ramp at field rate
// RULE_03: slow-ramp bit stretches time slot
// RULE_04: local smoothing only when bit3 set
// RULE_05: remote-two smoothing only when bit7 set
// RULE_06: lock bit freezes acoustic config writes
// RULE_07: minimum duty scales linearly full range
// RULE_08: auto mode freezes minimum duty registers
// RULE_09: above threshold run minimum, rise with span
// RULE_10: any critical exceed forces full duty
// RULE_11: limit 0x80 disables critical override
// RULE_12: override holds until below limit minus hysteresis
// RULE_13: overtemp pin pulls low past limit
// RULE_14: thresholds one degree per count
// RULE_15: four-bit hysteresis keeps minimum below threshold
// RULE_16: hold-select bit chooses off or minimum
// RULE_17: step per slot, stop exactly at target
module fac_limits
   import fac_pkg::*;
#(
   parameter int SLOT_FAST = fac_pkg::SLOT_FAST_CYC,
   parameter int SLOT_SLOW = fac_pkg::SLOT_SLOW_CYC
) (
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire fac_pkg::fac_temps_t temps,
   input  wire logic               temps_valid,
   output fac_pkg::fac_duty_t      fan_drive_output,
   output logic                    overtemp_pin_o,
   output logic                    overtemp_pin_oe_b,
   output logic                    irq
);
   import fac_pkg::*;

   // ==========================================================
   // Register state
   logic [7:0]  min_ff [3];
   logic [7:0]  start_ff [3];
   logic [7:0]  crit_ff [3];
   logic [7:0]  nxt_min [3];
   logic [7:0]  nxt_start [3];
   logic [7:0]  nxt_crit [3];
   logic [7:0]  hyst_r1l_ff, nxt_hyst_r1l;
   logic [7:0]  hyst_r2_ff, nxt_hyst_r2;
   logic [7:0]  acou_ff, nxt_acou;
   logic [13:0] ctrl_ff, nxt_ctrl;
   logic [7:0]  span_ff, nxt_span;
   logic [3:0]  stat_ff, nxt_stat;
   logic [3:0]  mask_ff, nxt_mask;
   fac_temps_t  temps_ff, nxt_temps;
   logic [2:0]  crit_ff_on, nxt_crit_on;
   logic [2:0]  run_ff, nxt_run;
   logic [7:0]  duty_ff [3];
   logic [7:0]  nxt_duty [3];
   logic [31:0] slot_cnt_ff, nxt_slot_cnt;
   logic        slot_tick;

   logic [7:0]  temp_ch [3];
   logic [3:0]  hyst_ch [3];
   logic [2:0]  crit_hit;
   // Release points per channel: limit or threshold less hysteresis
   logic [7:0]  crit_floor [3];
   logic [7:0]  start_floor [3];
   logic        wr_en;
   logic [7:0]  idx;
   logic        any_crit;
   logic        auto_on;
   logic        locked;

   // Per-channel views of captured codes and hysteresis nibbles
   assign temp_ch[0] = temps_ff.r1;
   assign temp_ch[1] = temps_ff.loc;
   assign temp_ch[2] = temps_ff.r2;
   assign hyst_ch[0] = hyst_r1l_ff[7:4];
   assign hyst_ch[1] = hyst_r1l_ff[3:0];     // RULE_15
   assign hyst_ch[2] = hyst_r2_ff[7:4];
   assign auto_on    = ctrl_ff[CTRL_AUTO_BIT];
   assign locked     = ctrl_ff[CTRL_LOCK_BIT];

   // ==========================================================
   // APB slave: zero wait states, unmapped reads zero with error
   assign pready = 1'b1;
   assign wr_en  = psel && penable && pwrite && pstrb[0];
   // Misaligned or out-of-window addresses fall on index 0x00, which is unmapped
   assign idx    = (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) ? paddr[9:2] : 8'h00;

   // Rate code to duty step per slot
   function automatic logic [7:0] step_of(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      unique case (code)     // RULE_01
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h04;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0C;
         3'h6: s = 8'h18;
         3'h7: s = 8'h30;
      endcase
      return s;
   endfunction

   // Index lies inside one of the two register windows
   function automatic logic map_hit(input logic [7:0] i);
      return (i >= IDX_FAN1_MIN && i <= IDX_HYST_R2) || (i >= IDX_ACOU_TWO && i <= IDX_SPAN);
   endfunction

   // Read mux over the register flops; zero wait, so no output stage
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (idx)
         IDX_FAN1_MIN:  rd_val[7:0]  = min_ff[0];
         IDX_FAN2_MIN:  rd_val[7:0]  = min_ff[1];
         IDX_FAN3_MIN:  rd_val[7:0]  = min_ff[2];
         IDX_R1_START:  rd_val[7:0]  = start_ff[0];
         IDX_LOC_START: rd_val[7:0]  = start_ff[1];
         IDX_R2_START:  rd_val[7:0]  = start_ff[2];
         IDX_R1_CRIT:   rd_val[7:0]  = crit_ff[0];
         IDX_LOC_CRIT:  rd_val[7:0]  = crit_ff[1];
         IDX_R2_CRIT:   rd_val[7:0]  = crit_ff[2];
         IDX_HYST_R1L:  rd_val[7:0]  = hyst_r1l_ff;
         IDX_HYST_R2:   rd_val[7:0]  = hyst_r2_ff;
         IDX_ACOU_TWO:  rd_val[7:0]  = acou_ff;
         IDX_CTRL:      rd_val[13:0] = ctrl_ff;
         IDX_IRQ_STAT:  rd_val[3:0]  = stat_ff;
         IDX_IRQ_MASK:  rd_val[3:0]  = mask_ff;
         IDX_STATUS:    rd_val[5:0]  = {run_ff, crit_ff_on};
         IDX_TEMP_R1:   rd_val[7:0]  = temps_ff.r1;
         IDX_TEMP_LOC:  rd_val[7:0]  = temps_ff.loc;
         IDX_TEMP_R2:   rd_val[7:0]  = temps_ff.r2;
         IDX_SPAN:      rd_val[7:0]  = span_ff;
         default:       rd_val       = 32'h0000_0000;
      endcase
   end
   assign prdata  = rd_val;
   assign pslverr = psel && penable && !map_hit(idx);

   // ==========================================================
   // Register writes
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         nxt_min[i]   = min_ff[i];
         nxt_start[i] = start_ff[i];
         nxt_crit[i]  = crit_ff[i];
      end
      nxt_hyst_r1l = hyst_r1l_ff;
      nxt_hyst_r2  = hyst_r2_ff;
      nxt_acou     = acou_ff;
      nxt_ctrl     = ctrl_ff;
      nxt_span     = span_ff;
      nxt_mask     = mask_ff;
      if (wr_en) begin
         for (int i = 0; i < 3; i++) begin
            if (idx == IDX_FAN1_MIN + 8'(i) && !auto_on)     // RULE_08
               nxt_min[i] = pwdata[7:0];
            if (idx == IDX_R1_START + 8'(i))
               nxt_start[i] = pwdata[7:0];
            if (idx == IDX_R1_CRIT + 8'(i))
               nxt_crit[i] = pwdata[7:0];
         end
         if (idx == IDX_HYST_R1L && !locked)
            nxt_hyst_r1l = pwdata[7:0];
         if (idx == IDX_HYST_R2 && !locked)
            nxt_hyst_r2 = pwdata[7:0];
         if (idx == IDX_ACOU_TWO && !locked)     // RULE_06
            nxt_acou = pwdata[7:0];
         // Lock is sticky until reset
         if (idx == IDX_CTRL)
            nxt_ctrl = {pwdata[13:2], pwdata[1] | locked, pwdata[0]};
         if (idx == IDX_SPAN)
            nxt_span = pwdata[7:0];
         if (idx == IDX_IRQ_MASK)
            nxt_mask = pwdata[3:0];
      end
   end

   // Register bank flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 3; i++) begin
            min_ff[i]   <= RST_MIN_DUTY;
            start_ff[i] <= RST_START;
            crit_ff[i]  <= RST_CRIT;
         end
         hyst_r1l_ff <= RST_HYST_R1L;
         hyst_r2_ff  <= RST_HYST_R2;
         acou_ff     <= RST_ACOU;
         ctrl_ff     <= 14'h0000;
         span_ff     <= RST_SPAN;
         mask_ff     <= 4'h0;
      end else begin
         min_ff      <= nxt_min;
         start_ff    <= nxt_start;
         crit_ff     <= nxt_crit;
         hyst_r1l_ff <= nxt_hyst_r1l;
         hyst_r2_ff  <= nxt_hyst_r2;
         acou_ff     <= nxt_acou;
         ctrl_ff     <= nxt_ctrl;
         span_ff     <= nxt_span;
         mask_ff     <= nxt_mask;
      end
   end

   // ==========================================================
   // Temperature capture: same-clock input, no synchroniser
   // Last codes stay in force while the measurement side is idle
   always_comb begin
      nxt_temps = temps_ff;
      if (temps_valid)
         nxt_temps = temps;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         temps_ff <= '0;
      end else begin
         temps_ff <= nxt_temps;
      end
   end

   // ==========================================================
   // Critical override and start/stop hysteresis per channel
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // One degree per count; signed-free compare on raw codes
         crit_hit[i] = (crit_ff[i] != CRIT_DISABLED) && (temp_ch[i] > crit_ff[i]);     // RULE_11 RULE_14
         // Saturate at zero so a low limit cannot wrap to a huge floor
         crit_floor[i]  = (crit_ff[i] > 8'(hyst_ch[i])) ? crit_ff[i] - 8'(hyst_ch[i]) : 8'h00;
         start_floor[i] = (start_ff[i] > 8'(hyst_ch[i])) ? start_ff[i] - 8'(hyst_ch[i]) : 8'h00;
         nxt_crit_on[i] = crit_ff_on[i];
         if (crit_ff[i] == CRIT_DISABLED)     // RULE_11
            nxt_crit_on[i] = 1'b0;
         else if (crit_hit[i])
            nxt_crit_on[i] = 1'b1;     // RULE_10
         else if (temp_ch[i] < crit_floor[i])
            nxt_crit_on[i] = 1'b0;     // RULE_12
         nxt_run[i] = run_ff[i];
         if (temp_ch[i] > start_ff[i])
            nxt_run[i] = 1'b1;     // RULE_09
         else if (temp_ch[i] <= start_floor[i])
            nxt_run[i] = 1'b0;     // RULE_15
      end
   end
   assign any_crit = |crit_ff_on;

   // Override and run flags; cleared by the hysteresis paths above, override also by a disabled limit
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         crit_ff_on <= 3'b000;
         run_ff     <= 3'b000;
      end else begin
         crit_ff_on <= nxt_crit_on;
         run_ff     <= nxt_run;
      end
   end

   // ==========================================================
   // Ramp slot divider: one-cycle enable per slot
   // Free running, so the first step of a ramp lands anywhere in a slot
   always_comb begin
      slot_tick    = 1'b0;
      nxt_slot_cnt = slot_cnt_ff + 32'd1;
      if (slot_cnt_ff >= 32'(ctrl_ff[CTRL_SLOW_BIT] ? SLOT_SLOW - 1 : SLOT_FAST - 1)) begin     // RULE_03
         slot_tick    = 1'b1;
         nxt_slot_cnt = 32'd0;
      end
   end

   // Slot counter flop
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_cnt_ff <= 32'd0;
      end else begin
         slot_cnt_ff <= nxt_slot_cnt;
      end
   end

   // ==========================================================
   // Per-fan target and ramped duty
   logic [7:0] target [3];
   logic [7:0] step   [3];
   logic       smooth [3];
   always_comb begin
      for (int f = 0; f < 3; f++) begin
         logic [1:0]  src;
         logic [15:0] lin;
         logic [8:0]  over;
         src  = ctrl_ff[CTRL_SRC_LSB + 2*f +: 2];
         if (src > 2'd2)
            src = 2'd2;
         over = {1'b0, temp_ch[src]} - {1'b0, start_ff[src]};
         lin  = 16'(min_ff[f]) + 16'(over[7:0]) * 16'(DUTY_FULL - min_ff[f]) / 16'(span_ff | 8'h01);
         if (!run_ff[src])
            target[f] = ctrl_ff[CTRL_HOLD_LSB + f] ? min_ff[f] : DUTY_OFF;     // RULE_16
         else if (over[8] || lin > 16'(DUTY_FULL))
            target[f] = (over[8]) ? min_ff[f] : DUTY_FULL;
         else
            target[f] = lin[7:0];     // RULE_07 RULE_09
         step[f]   = (src == 2'(FAC_SRC_R2)) ? step_of(acou_ff[ACOU_R2_RATE_LSB +: 3])
                                             : step_of(acou_ff[ACOU_LOC_RATE_LSB +: 3]);     // RULE_02
         smooth[f] = (src == 2'(FAC_SRC_R2)) ? acou_ff[ACOU_R2_EN_BIT]     // RULE_05
                   : (src == 2'(FAC_SRC_LOC)) ? acou_ff[ACOU_LOC_EN_BIT] : 1'b0;     // RULE_04
         nxt_duty[f] = duty_ff[f];
         if (!auto_on)
            nxt_duty[f] = min_ff[f];
         else if (!smooth[f])
            nxt_duty[f] = target[f];
         else if (slot_tick) begin
            // Clamp to target so a large step never overshoots
            if (target[f] > duty_ff[f])
               nxt_duty[f] = (target[f] - duty_ff[f] > step[f]) ? duty_ff[f] + step[f] : target[f];     // RULE_17
            else if (target[f] < duty_ff[f])
               nxt_duty[f] = (duty_ff[f] - target[f] > step[f]) ? duty_ff[f] - step[f] : target[f];     // RULE_17
         end
      end
   end

   // Duty flops start at the minimum-duty reset value
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int f = 0; f < 3; f++) begin
            duty_ff[f] <= RST_MIN_DUTY;
         end
      end else begin
         duty_ff <= nxt_duty;
      end
   end

   // ==========================================================
   // Interrupt status: per-channel critical plus any run start; set wins over clear
   always_comb begin
      nxt_stat = stat_ff;
      if (wr_en && idx == IDX_IRQ_STAT)
         nxt_stat = stat_ff & ~pwdata[3:0];
      nxt_stat = nxt_stat | {|(nxt_run & ~run_ff), crit_hit};
   end
   assign irq = |(stat_ff & mask_ff);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         // Sticky bits only; the mask lives with the register bank
         stat_ff <= 4'h0;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   // ==========================================================
   // Outputs: override beats loop and software
   logic [7:0] drive_ch [3];
   for (genvar g = 0; g < 3; g++) begin : g_drive
      assign drive_ch[g] = any_crit ? DUTY_FULL : duty_ff[g];     // RULE_10
   end
   assign fan_drive_output = {drive_ch[2], drive_ch[1], drive_ch[0]};
   assign overtemp_pin_o        = 1'b0;
   assign overtemp_pin_oe_b     = !(ctrl_ff[CTRL_PINOUT_BIT] && (|crit_ff_on));     // RULE_13
endmodule

// file: design/fac_pkg.sv
package fac_pkg;
   // ==========================================================
   // Register offsets (word indices; some printed offsets are not word aligned, so index*4)
   localparam logic [7:0] IDX_FAN1_MIN    = 8'h64;
   localparam logic [7:0] IDX_FAN2_MIN    = 8'h65;
   localparam logic [7:0] IDX_FAN3_MIN    = 8'h66;
   localparam logic [7:0] IDX_R1_START    = 8'h67;
   localparam logic [7:0] IDX_LOC_START   = 8'h68;
   localparam logic [7:0] IDX_R2_START    = 8'h69;
   localparam logic [7:0] IDX_R1_CRIT     = 8'h6A;
   localparam logic [7:0] IDX_LOC_CRIT    = 8'h6B;
   localparam logic [7:0] IDX_R2_CRIT     = 8'h6C;
   localparam logic [7:0] IDX_HYST_R1L    = 8'h6D;
   localparam logic [7:0] IDX_HYST_R2     = 8'h6E;
   localparam logic [7:0] IDX_ACOU_TWO    = 8'h80;
   localparam logic [7:0] IDX_CTRL        = 8'h81;
   localparam logic [7:0] IDX_IRQ_STAT    = 8'h82;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h83;
   localparam logic [7:0] IDX_STATUS      = 8'h84;
   localparam logic [7:0] IDX_TEMP_R1     = 8'h85;
   localparam logic [7:0] IDX_TEMP_LOC    = 8'h86;
   localparam logic [7:0] IDX_TEMP_R2     = 8'h87;
   localparam logic [7:0] IDX_SPAN        = 8'h88;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_MIN_DUTY    = 8'h80;
   localparam logic [7:0] RST_START       = 8'h5A;
   localparam logic [7:0] RST_CRIT        = 8'h64;
   localparam logic [7:0] RST_HYST_R1L    = 8'h44;
   localparam logic [7:0] RST_HYST_R2     = 8'h40;
   localparam logic [7:0] RST_ACOU        = 8'h00;
   localparam logic [7:0] RST_SPAN        = 8'h20;
   localparam logic [7:0] CRIT_DISABLED   = 8'h80;
   localparam logic [7:0] DUTY_FULL       = 8'hFF;
   localparam logic [7:0] DUTY_OFF        = 8'h00;

   // ==========================================================
   // Field positions
   localparam int ACOU_LOC_RATE_LSB = 0;
   localparam int ACOU_LOC_EN_BIT   = 3;
   localparam int ACOU_R2_RATE_LSB  = 4;
   localparam int ACOU_R2_EN_BIT    = 7;
   localparam int CTRL_AUTO_BIT     = 0;
   localparam int CTRL_LOCK_BIT     = 1;
   localparam int CTRL_SLOW_BIT     = 2;
   localparam int CTRL_PINOUT_BIT   = 3;
   localparam int CTRL_HOLD_LSB     = 4;
   localparam int CTRL_SRC_LSB      = 8;

   // ==========================================================
   // Ramp timing: slot = full sweep at step 1 divided by 255 steps
   localparam int  CLK_HZ          = 20_000_000;
   localparam real SWEEP_FAST_SEC  = 37.5;
   localparam real SWEEP_SLOW_SEC  = 52.2;
   localparam int  SLOT_FAST_CYC   = int'($floor(SWEEP_FAST_SEC * CLK_HZ / 255.0));
   localparam int  SLOT_SLOW_CYC   = int'($floor(SWEEP_SLOW_SEC * CLK_HZ / 255.0));

   typedef enum logic [1:0] {
      FAC_SRC_R1,
      FAC_SRC_LOC,
      FAC_SRC_R2
   } fac_src_t;

   typedef struct packed {
      logic [7:0] r1;
      logic [7:0] loc;
      logic [7:0] r2;
   } fac_temps_t;

   typedef struct packed {
      logic [7:0] fan3;
      logic [7:0] fan2;
      logic [7:0] fan1;
   } fac_duty_t;
endpackage

// file: dv/fac_fan_model.sv
module fac_fan_model
   import fac_pkg::*;
(
   input wire fac_pkg::fac_duty_t drive,
   input wire logic               pin_o,
   input wire logic               pin_oe_b,
   output logic                   pin_wire,
   output logic [2:0]             spinning
);
   timeunit 1ns;
   timeprecision 1ps;
   // Board pull-up holds the open-drain line high when released
   assign pin_wire = pin_oe_b ? 1'b1 : pin_o;
   // A fan stands still only at zero duty
   assign spinning = {drive.fan3 != DUTY_OFF, drive.fan2 != DUTY_OFF, drive.fan1 != DUTY_OFF};
endmodule

// file: dv/fac_limits_bench.sv
module fac_limits_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fac_pkg::*;
   logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, temps_valid;
   logic        irq, pin_o, pin_oe_b, pin_wire, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [2:0]  spin;
   fac_temps_t  temps;
   fac_duty_t   duty;
   int          err_total, samples_checked, cyc;
   int          step_tab[8] = '{1, 2, 3, 4, 8, 12, 24, 48};

   fac_limits #(.SLOT_FAST(4), .SLOT_SLOW(6)) fac_limits_i (
      .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .temps(temps),
      .temps_valid(temps_valid), .fan_drive_output(duty), .overtemp_pin_o(pin_o),
      .overtemp_pin_oe_b(pin_oe_b), .irq(irq));
   fac_fan_model fac_fan_model_i (.drive(duty), .pin_o(pin_o), .pin_oe_b(pin_oe_b), .pin_wire(pin_wire),
      .spinning(spin));

   // ==========================================================
   // Clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; pready is waited for, never assumed
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      apb(idx, 1'b0, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic conclude();
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset_table();
      logic [7:0] tab[11] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40};
      for (int i = 0; i < 11; i++) rdchk("reset reg", IDX_FAN1_MIN + 8'(i), {24'h0, tab[i]});
      rdchk("span reset", IDX_SPAN, 32'h20);
      apb(8'h70, 1'b0, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
   endtask
   task automatic t_min_duty();
      apb(IDX_FAN1_MIN, 1'b1, 32'h00);
      apb(IDX_FAN2_MIN, 1'b1, 32'h40);
      apb(IDX_FAN3_MIN, 1'b1, 32'hFF);
      repeat (2) @(posedge sys_clk);
      chk("manual duty", 32'hFF4000, {8'h0, duty});
      chk("fans spinning", 32'h6, {29'h0, spin});
      apb(IDX_FAN2_MIN, 1'b1, 32'h80);
   endtask
   // Local channel crosses its limit with pin output and interrupt in play
   task automatic t_critical();
      apb(IDX_CTRL, 1'b1, 32'h8);
      temps.loc <= 8'h65;
      repeat (4) @(posedge sys_clk);
      chk("override duty", 32'hFFFFFF, {8'h0, duty});
      chk("pin low", 32'h0, {31'h0, pin_wire});
      chk("masked irq", 32'h0, {31'h0, irq});
      apb(IDX_IRQ_MASK, 1'b1, 32'h2);
      @(posedge sys_clk);
      chk("unmasked irq", 32'h1, {31'h0, irq});
      temps.loc <= 8'h61;
      repeat (4) @(posedge sys_clk);
      chk("held duty", 32'hFFFFFF, {8'h0, duty});
      temps.loc <= 8'h5F;
      repeat (4) @(posedge sys_clk);
      chk("released duty", 32'hFF8000, {8'h0, duty});
      chk("pin released", 32'h1, {31'h0, pin_wire});
      apb(IDX_IRQ_STAT, 1'b1, 32'h2);
      @(posedge sys_clk);
      chk("cleared irq", 32'h0, {31'h0, irq});
      apb(IDX_LOC_CRIT, 1'b1, 32'h80);
      temps.loc <= 8'h7F;
      repeat (4) @(posedge sys_clk);
      chk("disabled limit", 32'hFF8000, {8'h0, duty});
      temps.loc <= 8'h20;
      apb(IDX_LOC_CRIT, 1'b1, 32'h64);
   endtask
   // Fan1 follows remote two from off to full at the chosen step and slot
   task automatic t_ramp(input int code, input int slow);
      int prev, last, n, s;
      apb(IDX_ACOU_TWO, 1'b1, 32'h80 | (code << 4));
      apb(IDX_CTRL, 1'b1, 32'h221 | (slow << 2));
      temps.r2 <= 8'h60;
      prev = 0;
      last = -1;
      n = 0;
      while (duty.fan1 !== 8'hFF && n < 3000) begin
         @(negedge sys_clk);
         n++;
         if (duty.fan1 !== 8'(prev)) begin
            s = (prev + step_tab[code] > 255) ? 255 : prev + step_tab[code];
            chk("ramp step", 32'(s), {24'h0, duty.fan1});
            if (last >= 0) chk("slot gap", slow ? 32'd6 : 32'd4, 32'(n - last));
            last = n;
            prev = duty.fan1;
         end
      end
      chk("ramp end", 32'hFF, {24'h0, duty.fan1});
      apb(IDX_ACOU_TWO, 1'b1, 32'h0);
      temps.r2 <= 8'h10;
      // Capture, run flag and duty flop each take one edge
      repeat (4) @(posedge sys_clk);
      chk("unsmoothed drop", 32'h0, {24'h0, duty.fan1});
   endtask
   task automatic t_auto();
      apb(IDX_R2_START, 1'b1, 32'h30);
      apb(IDX_SPAN, 1'b1, 32'h20);
      apb(IDX_CTRL, 1'b1, 32'h221);
      repeat (4) @(posedge sys_clk);
      chk("below threshold", 32'h008000, {8'h0, duty});
      apb(IDX_FAN2_MIN, 1'b1, 32'h11);
      rdchk("auto min frozen", IDX_FAN2_MIN, 32'h80);
      for (int c = 0; c < 8; c++) t_ramp(c, 0);
      t_ramp(3, 1);
   endtask
   task automatic t_lock();
      apb(IDX_ACOU_TWO, 1'b1, 32'h35);
      apb(IDX_CTRL, 1'b1, 32'h223);
      apb(IDX_ACOU_TWO, 1'b1, 32'hCA);
      rdchk("locked config", IDX_ACOU_TWO, 32'h35);
      // Only a reset lifts the lock
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      apb(IDX_ACOU_TWO, 1'b1, 32'hCA);
      rdchk("unlocked config", IDX_ACOU_TWO, 32'hCA);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {rst_b, psel, penable, pwrite, temps_valid} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      temps = {8'h10, 8'h20, 8'h10};
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      temps_valid <= 1'b1;
      t_reset_table();
      t_min_duty();
      t_critical();
      t_auto();
      t_lock();
      conclude();
   end
endmodule

// file: dv/fac_limits_properties.sv
module fac_limits_chk
   import fac_pkg::*;
#(
   parameter int SLOT_FAST = 4,
   parameter int SLOT_SLOW = 6
) (
   input wire logic                sys_clk,
   input wire logic                rst_b,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic                pready,
   input wire logic [31:0]         prdata,
   input wire logic                pslverr,
   input wire fac_pkg::fac_temps_t temps,
   input wire logic                temps_valid,
   input wire fac_pkg::fac_duty_t  fan_drive_output,
   input wire logic                overtemp_pin_o,
   input wire logic                overtemp_pin_oe_b,
   input wire logic                irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lim_ff;
   logic [7:0] nxt_lim;
   logic       acc;
   logic       mapped;
   logic       hot;
   // ==========================================================
   // Shadow of the local critical limit; only bus writes move it
   assign acc = psel & penable;
   always_comb begin
      nxt_lim = lim_ff;
      if (acc && pwrite && pstrb[0] && paddr == {2'h0, IDX_LOC_CRIT, 2'h0}) begin
         nxt_lim = pwdata[7:0];
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lim_ff <= RST_CRIT;
      end else begin
         lim_ff <= nxt_lim;
      end
   end
   // Word aligned, inside one of the two index ranges
   assign mapped = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 &&
      ((paddr[9:2] >= IDX_FAN1_MIN && paddr[9:2] <= IDX_HYST_R2) || (paddr[9:2] >= IDX_ACOU_TWO && paddr[9:2] <= IDX_SPAN));
   assign hot = temps_valid && temps.loc > lim_ff && lim_ff != CRIT_DISABLED;
   // ==========================================================
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_ready_zero_wait: assert property (acc |-> pready) else $error("pready low in access phase");
   a_unmapped_error: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped access");
   a_mapped_no_error: assert property (acc && mapped |-> !pslverr) else $error("error on mapped access");
   a_error_only_access: assert property (pslverr |-> acc) else $error("error outside access phase");
   a_pin_level_low: assert property (overtemp_pin_o == 1'b0) else $error("pin driven high");
   a_pin_means_full: assert property (!overtemp_pin_oe_b |-> fan_drive_output == {3{DUTY_FULL}})
      else $error("pin pulled without full duty");
   a_crit_forces_full: assert property (hot [*3] |-> fan_drive_output == {3{DUTY_FULL}})
      else $error("critical exceed without full duty");
   a_release_quiet: assert property ($rose(rst_b) |-> !irq && overtemp_pin_oe_b && fan_drive_output.fan1 == RST_MIN_DUTY)
      else $error("outputs not at reset state");
   c_override: cover property (!overtemp_pin_oe_b);
   c_bus_error: cover property (acc && pslverr);
   c_irq_rise: cover property ($rose(irq));
endmodule

bind fac_limits fac_limits_chk #(.SLOT_FAST(SLOT_FAST), .SLOT_SLOW(SLOT_SLOW)) fac_limits_chk_i (
   .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .temps(temps),
   .temps_valid(temps_valid), .fan_drive_output(fan_drive_output), .overtemp_pin_o(overtemp_pin_o),
   .overtemp_pin_oe_b(overtemp_pin_oe_b), .irq(irq));
